// ==== verilog/snooze_pkg.sv ====
// constants shared by the snooze uart receiver and its bit sampler
// assumes one 250 MHz clock and an apb master with 32-bit data
`default_nettype none
package snooze_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] MASK_OFF   = 8'h08;
	localparam logic [7:0] DATA_OFF   = 8'h0c;
	localparam logic [7:0] DIV_OFF    = 8'h10;
	localparam logic [7:0] PSC_OFF    = 8'h14;
	// control bit positions
	localparam int CTRL_START  = 0;
	localparam int CTRL_WAKE   = 1;
	localparam int CTRL_SUPP   = 2;
	localparam int CTRL_ERRIE  = 3;
	localparam int CTRL_STOP   = 4;
	localparam int CTRL_VECT   = 5;
	localparam int CTRL_LSMODE = 6;
	localparam int CTRL_XTAL   = 7;
	// irq status bit positions
	localparam int IRQ_RXDONE = 0;
	localparam int IRQ_RXERR  = 1;
	localparam int IRQ_WAKE   = 2;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] DIV_RST  = 7'h4f;
	localparam logic [3:0] PSC_RST  = 4'h0;
	// transition times in ns, clock period in ns
	localparam int CLK_NS        = 4;
	localparam int STOP_SNZ_MIN  = 18000;
	localparam int STOP_SNZ_MAX  = 65000;
	localparam int SNZ_HS_NS     = 6650;
	localparam int SNZ_LS_NS     = 1100;
	// least times round up
	localparam int STOP_SNZ_CYC  = (STOP_SNZ_MIN + CLK_NS - 1) / CLK_NS;
	localparam int SNZ_HS_CYC    = (SNZ_HS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SNZ_LS_CYC    = (SNZ_LS_NS + CLK_NS - 1) / CLK_NS;
	// wait clocks after release
	localparam int WAIT_VECT     = 7;
	localparam int WAIT_PLAIN    = 1;
	localparam int WAIT_X_VECT   = 11;
	localparam int WAIT_X_PLAIN  = 5;
	localparam int DATA_BITS     = 8;
	typedef enum {PW_RUN, PW_STOP, PW_ENTER, PW_SNOOZE, PW_EXIT, PW_WAIT}
		power_type;
endpackage
`default_nettype wire

// ==== verilog/rx_sampler.sv ====
// serial frame sampler: start, 8 data, even parity, one stop
// assumes a synchronous rx input; bit timing comes from an internal counter
`default_nettype none
module rx_sampler (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       enable,
	input  wire logic [3:0] psc,
	input  wire logic [6:0] div,
	// line
	input  wire logic       rx,
	// result
	output logic            started,
	output logic            done,
	output logic [7:0]      data,
	output logic            par_err,
	output logic            frm_err
);
	import snooze_pkg::*;

	typedef enum {S_IDLE, S_START, S_BITS, S_PAR, S_STOP} samp_type;

	samp_type    st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [3:0]  bit_q, bit_d;
	logic [7:0]  sh_q, sh_d;
	logic        par_q, par_d, rxp_q;
	logic        done_q, done_d, pe_q, pe_d, fe_q, fe_d;
	logic [15:0] period;

	// bit period = 2^psc * (div+1)*2, as a two-level divider would give
	assign period = 16'(({9'h0, div} + 16'h1) << (psc + 4'h1));

	/////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q - 16'h1;
		bit_d = bit_q;
		sh_d = sh_q;
		par_d = par_q;
		done_d = 1'b0;
		pe_d = pe_q;
		fe_d = fe_q;
		case (st_q)
			S_IDLE: begin
				cnt_d = 16'(period >> 1);
				if (enable && rxp_q && !rx) begin
					st_d = S_START;
				end
			end
			S_START: begin
				if (cnt_q == 16'h0) begin
					// false start is dropped, not flagged
					st_d = rx ? S_IDLE : S_BITS;
					cnt_d = period - 16'h1; // the zero cycle closes the bit
					bit_d = 4'h0;
					par_d = 1'b0;
				end
			end
			S_BITS: begin
				if (cnt_q == 16'h0) begin
					sh_d = {rx, sh_q[7:1]};
					par_d = par_q ^ rx;
					cnt_d = period - 16'h1;
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'(DATA_BITS - 1)) begin
						st_d = S_PAR;
					end
				end
			end
			S_PAR: begin
				if (cnt_q == 16'h0) begin
					pe_d = par_q ^ rx;
					cnt_d = period - 16'h1;
					st_d = S_STOP;
				end
			end
			S_STOP: begin
				if (cnt_q == 16'h0) begin
					fe_d = !rx;
					done_d = 1'b1;
					st_d = S_IDLE;
				end
			end
			default: st_d = S_IDLE;
		endcase
		if (!enable) begin
			st_d = S_IDLE;
		end
	end

	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= S_IDLE;
			cnt_q <= 16'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h0;
			par_q <= 1'b0;
			rxp_q <= 1'b1;
			done_q <= 1'b0;
			pe_q <= 1'b0;
			fe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			par_q <= par_d;
			rxp_q <= rx;
			done_q <= done_d;
			pe_q <= pe_d;
			fe_q <= fe_d;
		end
	end

	assign started = (st_q == S_IDLE) && enable && rxp_q && !rx;
	assign done = done_q;
	assign data = sh_q;
	assign par_err = pe_q;
	assign frm_err = fe_q;
endmodule
`default_nettype wire

// ==== verilog/uart_snooze_receiver.sv ====
// uart receive channel with stop/snooze power sequencing and apb registers
// assumes apb master on pclk; inputs synchronous to pclk
`default_nettype none

module uart_snooze_receiver #(
	parameter int STOP_SNZ_CYCLES = snooze_pkg::STOP_SNZ_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// serial line
	input  wire logic        uart_rx_pin,
	// power state seen by the channel
	output logic             cpu_clock_run,
	output logic             snooze_active,
	// interrupt
	output logic             irq
);
	import snooze_pkg::*;

	// the entry timer is 16 bits wide; a larger count would wrap
	if (STOP_SNZ_CYCLES < 1 || STOP_SNZ_CYCLES > 65535) begin : g_bad_count
		$error("stop to snooze count must lie in 1 to 65535");
	end

	logic [7:0]  ctrl_q, ctrl_d;
	logic [2:0]  stat_q, stat_d, mask_q, mask_d;
	logic [2:0]  err_q, err_d;            // parity, framing, overrun
	logic [7:0]  rbuf_q, rbuf_d;
	logic        full_q, full_d;
	logic [6:0]  div_q, div_d;
	logic [3:0]  psc_q, psc_d;
	power_type   pw_q, pw_d;
	logic [15:0] tmr_q, tmr_d;
	logic        bad_q, bad_d;            // reception began outside stop with wake armed
	logic        wr, rd, rx_en, started, done, pe, fe;
	logic [7:0]  rdata, sdata;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;

	/////////////////////////////////////////////////////////////////////
	// decoding used for unmapped detection; the read mux decodes the offsets itself
	function automatic logic known(input logic [7:0] a);
		known = (a == CTRL_OFF) || (a == STATUS_OFF) || (a == MASK_OFF) ||
			(a == DATA_OFF) || (a == DIV_OFF) || (a == PSC_OFF);
	endfunction
	assign pslverr = psel && penable && !known(paddr);

	// receiver runs in normal operation or in snooze, never in plain stop
	assign rx_en = ctrl_q[CTRL_START] && ((pw_q == PW_RUN) ||
		(pw_q == PW_STOP && ctrl_q[CTRL_WAKE]) ||
		pw_q == PW_ENTER || pw_q == PW_SNOOZE);

	rx_sampler u_samp (    // single channel, the only one with snooze
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (rx_en),
		.psc     (psc_q),
		.div     (div_q),
		.rx      (uart_rx_pin),
		.started (started),
		.done    (done),
		.data    (sdata),
		.par_err (pe),
		.frm_err (fe)
	);

	/////////////////////////////////////////////////////////////////////
	// power sequencer: stop, clock restart delay, snooze, wake wait
	always_comb begin
		pw_d = pw_q;
		tmr_d = (tmr_q != 16'h0) ? tmr_q - 16'h1 : 16'h0;
		case (pw_q)
			PW_RUN: begin
				if (ctrl_q[CTRL_STOP]) begin
					pw_d = PW_STOP;
				end
			end
			PW_STOP: begin
				if (started && ctrl_q[CTRL_WAKE]) begin
					pw_d = PW_ENTER;
					tmr_d = 16'(STOP_SNZ_CYCLES);
				end else if (!ctrl_q[CTRL_STOP]) begin
					pw_d = PW_RUN;
				end
			end
			PW_ENTER: begin
				if (tmr_q == 16'h0) begin
					pw_d = PW_SNOOZE;
				end
			end
			PW_SNOOZE: begin
				if (done) begin
					pw_d = PW_EXIT;
					tmr_d = ctrl_q[CTRL_LSMODE] ? 16'(SNZ_LS_CYC)
						: 16'(SNZ_HS_CYC);
				end
			end
			PW_EXIT: begin
				if (tmr_q == 16'h0) begin
					pw_d = PW_WAIT;
					if (ctrl_q[CTRL_XTAL]) begin
						tmr_d = ctrl_q[CTRL_VECT] ? 16'(WAIT_X_VECT)
							: 16'(WAIT_X_PLAIN);
					end else begin
						tmr_d = ctrl_q[CTRL_VECT] ? 16'(WAIT_VECT)
							: 16'(WAIT_PLAIN);
					end
				end
			end
			PW_WAIT: begin
				if (tmr_q == 16'h1) begin
					pw_d = PW_RUN;
				end
			end
			default: pw_d = PW_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pw_q <= PW_RUN;
			tmr_q <= 16'h0;
		end else begin
			pw_q <= pw_d;
			tmr_q <= tmr_d;
		end
	end

	assign cpu_clock_run = (pw_q == PW_RUN);
	assign snooze_active = (pw_q == PW_SNOOZE) || (pw_q == PW_ENTER);

	/////////////////////////////////////////////////////////////////////
	// registers, flags and receive buffer
	always_comb begin
		logic [2:0] ev;
		logic [2:0] errs;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		div_d = div_q;
		psc_d = psc_q;
		err_d = err_q;
		rbuf_d = rbuf_q;
		full_d = full_q;
		bad_d = bad_q;
		ev = 3'h0;
		errs = {done && full_q, done && fe, done && pe};
		// a start seen while awake and armed taints the frame
		if (started) begin
			bad_d = ctrl_q[CTRL_WAKE] && (pw_q != PW_STOP);
		end
		if (wr) begin
			if (paddr == CTRL_OFF) begin
				ctrl_d = pwdata[7:0];
			end else if (paddr == MASK_OFF) begin
				mask_d = pwdata[2:0];
			end else if (paddr == DIV_OFF) begin
				div_d = pwdata[15:9];
			end else if (paddr == PSC_OFF) begin
				psc_d = pwdata[3:0];
			end else if (paddr == STATUS_OFF) begin
				err_d = err_q & ~pwdata[6:4];   // write one clears errors
			end
		end
		if (rd && paddr == DATA_OFF) begin
			full_d = 1'b0;
		end
		// the wake request drops the stop request on the way back
		if (pw_q == PW_WAIT && pw_d == PW_RUN) begin
			ctrl_d[CTRL_STOP] = 1'b0;
		end
		if (done) begin
			rbuf_d = sdata;
			full_d = 1'b1;
			ev[IRQ_RXDONE] = 1'b1;
			if (!ctrl_q[CTRL_SUPP] && |errs) begin
				err_d = err_d | errs;
				ev[IRQ_RXERR] = ctrl_q[CTRL_ERRIE];
			end
		end
		ev[IRQ_WAKE] = (pw_q == PW_WAIT) && (pw_d == PW_RUN);
		// read clears status, a same-cycle event survives
		stat_d = ((rd && paddr == STATUS_OFF) ? 3'h0 : stat_q) | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			mask_q <= 3'h0;
			div_q <= DIV_RST;
			psc_q <= PSC_RST;
			err_q <= 3'h0;
			rbuf_q <= 8'h0;
			full_q <= 1'b0;
			bad_q <= 1'b0;
			stat_q <= 3'h0;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			div_q <= div_d;
			psc_q <= psc_d;
			err_q <= err_d;
			rbuf_q <= rbuf_d;
			full_q <= full_d;
			bad_q <= bad_d;
			stat_q <= stat_d;
		end
	end

	// read mux; bits above each field read zero
	always_comb begin
		rdata = 8'h0;
		if (paddr == CTRL_OFF) begin
			rdata = ctrl_q;
		end else if (paddr == STATUS_OFF) begin
			rdata = {bad_q, err_q, full_q, stat_q};
		end else if (paddr == MASK_OFF) begin
			rdata = {5'h0, mask_q};
		end else if (paddr == DATA_OFF) begin
			rdata = rbuf_q;
		end else if (paddr == PSC_OFF) begin
			rdata = {4'h0, psc_q};
		end
		if (paddr == DIV_OFF) begin
			prdata = {16'h0, div_q, 9'h0};
		end else begin
			prdata = {24'h0, rdata};
		end
	end

	assign irq = |(stat_q & mask_q);

	/////////////////////////////////////////////////////////////////////
	// checks
	property p_stop_halts;
		@(posedge pclk) disable iff (!presetn)
		(pw_q == PW_STOP && !ctrl_q[CTRL_WAKE]) |-> !rx_en;
	endproperty
	a_stop_halts: assert property (p_stop_halts)
		else $error("receiver active in stop without wake enable");

	property p_start_enters;
		@(posedge pclk) disable iff (!presetn)
		(pw_q == PW_STOP && started && ctrl_q[CTRL_WAKE]) |=>
			pw_q == PW_ENTER;
	endproperty
	a_start_enters: assert property (p_start_enters)
		else $error("start edge in stop did not begin snooze entry");

	property p_enter_min;
		@(posedge pclk) disable iff (!presetn)
		$rose(pw_q == PW_ENTER) |-> tmr_q == 16'(STOP_SNZ_CYCLES);
	endproperty
	a_enter_min: assert property (p_enter_min)
		else $error("stop to snooze delay wrong");

	property p_suppress;
		@(posedge pclk) disable iff (!presetn)
		(done && ctrl_q[CTRL_SUPP]) |=> $stable(err_q) && !stat_q[IRQ_RXERR];
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("error flag set while suppressed");

	property p_done_wakes;
		@(posedge pclk) disable iff (!presetn)
		(pw_q == PW_SNOOZE && done) |=> pw_q == PW_EXIT && stat_q[IRQ_RXDONE];
	endproperty
	a_done_wakes: assert property (p_done_wakes)
		else $error("snooze reception did not start wake-up");

	property p_exit_hs;
		@(posedge pclk) disable iff (!presetn)
		($rose(pw_q == PW_EXIT) && !ctrl_q[CTRL_LSMODE]) |->
			tmr_q == 16'(SNZ_HS_CYC);
	endproperty
	a_exit_hs: assert property (p_exit_hs)
		else $error("snooze to normal delay wrong");

	property p_wait_plain;
		@(posedge pclk) disable iff (!presetn)
		($rose(pw_q == PW_WAIT) && !ctrl_q[CTRL_VECT] && !ctrl_q[CTRL_XTAL])
			|-> ##1 pw_q == PW_RUN;
	endproperty
	a_wait_plain: assert property (p_wait_plain)
		else $error("plain wake wait is not one clock");

	property p_wait_xtal;
		@(posedge pclk) disable iff (!presetn)
		($rose(pw_q == PW_WAIT) && ctrl_q[CTRL_VECT] && ctrl_q[CTRL_XTAL])
			|-> ##10 (pw_q == PW_WAIT && tmr_q == 16'h1) ##1 pw_q == PW_RUN;
	endproperty
	a_wait_xtal: assert property (p_wait_xtal)
		else $error("crystal vectored wait is not eleven clocks");
endmodule
`default_nettype wire

// ==== verif/uart_tx_model.sv ====
// remote serial transmitter model that faces the snooze receiver
// assumes the bench calls send() and gives the bit length in pclk cycles
`default_nettype none
module uart_tx_model (
	// clock
	input  wire logic pclk,
	// serial line
	output logic      tx
);
	timeunit 1ns;
	timeprecision 1ps;

	// the line's pull-up holds it high outside frames
	initial tx = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// one frame: start, 8 data lsb first, even parity, stop
	// bit length exact, so the rate sits inside the acceptance window
	task automatic send(input logic [7:0] b, input logic bp, input logic bs,
		input int bc);
		logic [10:0] f;
		f = {~bs, ^b ^ bp, b, 1'b0}; // bp and bs break a frame on demand
		@(posedge pclk);
		for (int i = 0; i < 11; i++) begin
			tx <= f[i]; // fixed line rate
			repeat (bc) @(posedge pclk);
		end
		tx <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== verif/uart_snooze_receiver_bench.sv ====
// self-checking bench for the snooze uart receiver
// assumes the design package and the remote transmitter model
`default_nettype none
module uart_snooze_receiver_bench import snooze_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// reset divisor 79 at prescaler exponent 0
	localparam int BITP = 160;
	typedef struct packed {
		logic [7:0] b;
		logic       bp;
		logic       bs;
		logic [7:0] st;
		logic [7:0] m;
	} row_type;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, rx, run, snz, irq;
	int          miscompares = 0;
	int          check_count = 0;
	int          n;
	logic [7:0]  ro [4] = '{CTRL_OFF, STATUS_OFF, DIV_OFF, PSC_OFF};
	logic [31:0] re [4] = '{32'h0, 32'h0, 32'h9e00, 32'h0};
	// system clock taken as the on-chip oscillator in the first two cases, the crystal in the third
	logic [7:0]  md [3] = '{8'h00, 8'h60, 8'ha0};
	int          wt [3] = '{SNZ_HS_CYC + WAIT_PLAIN, SNZ_LS_CYC + WAIT_VECT,
		SNZ_HS_CYC + WAIT_X_VECT};
	row_type     rows [4] = '{'{8'ha5, 1'b0, 1'b0, 8'h09, 8'h3b},
		'{8'h00, 1'b0, 1'b0, 8'h09, 8'h3b},
		'{8'h5a, 1'b1, 1'b0, 8'h12, 8'h32},
		'{8'hff, 1'b0, 1'b1, 8'h22, 8'h32}};

	always #2 pclk = ~pclk;

	uart_snooze_receiver #(.STOP_SNZ_CYCLES(20)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .uart_rx_pin(rx),
		.cpu_clock_run(run), .snooze_active(snz), .irq(irq));
	uart_tx_model remote (.pclk(pclk), .tx(rx));

	////////////////////////////////////////////////////////////////////////
	// comparison, apb transfer, wake wait and closing
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask

	// request held until pready is seen high at a rising edge; read data
	// is taken at that edge, before the edge's own updates land
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wake_wait();
		n = 0;
		while (run !== 1'b1 && n < 4000) begin
			@(negedge pclk);
			n++;
		end
	endtask

	task automatic note(input string s);
		$display("test %s done", s);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check(snz, 1'b0);
		check(run, 1'b1);
		check(irq, 1'b0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ro[i], 32'h0);
			check(rd, re[i]);
		end
		note("reset");
		// channel start after init, error irq chosen up front
		apb(1'b1, CTRL_OFF, 32'h09);
		foreach (rows[i]) begin
			remote.send(rows[i].b, rows[i].bp, rows[i].bs, BITP);
			apb(1'b0, STATUS_OFF, 32'h0);
			check(rd & 32'(rows[i].m), 32'(rows[i].st));
			apb(1'b1, STATUS_OFF, 32'h70);
			apb(1'b0, DATA_OFF, 32'h0);
			if (rows[i].st[0])
				check(rd[7:0], rows[i].b);
		end
		// a second frame before the data read overruns the buffer
		remote.send(8'ha5, 1'b0, 1'b0, BITP);
		remote.send(8'h00, 1'b0, 1'b0, BITP);
		apb(1'b0, STATUS_OFF, 32'h0);
		check(rd & 32'h7b, 32'h4b);
		apb(1'b1, STATUS_OFF, 32'h70);
		apb(1'b0, DATA_OFF, 32'h0);
		check(rd[7:0], 8'h00);
		check(irq, 1'b0);
		note("rows");
		apb(1'b1, CTRL_OFF, 32'h19);
		remote.send(8'h33, 1'b0, 1'b0, BITP);
		check(snz, 1'b0);
		check(run, 1'b0);
		apb(1'b0, STATUS_OFF, 32'h0);
		check(rd[0], 1'b0);
		apb(1'b1, CTRL_OFF, 32'h09);
		note("stop");
		apb(1'b1, CTRL_OFF, 32'h0b);
		remote.send(8'h44, 1'b0, 1'b0, BITP);
		apb(1'b0, STATUS_OFF, 32'h0);
		check(rd[7], 1'b1);
		apb(1'b1, STATUS_OFF, 32'h70);
		apb(1'b0, DATA_OFF, 32'h0);
		note("early");
		apb(1'b1, MASK_OFF, 32'h07);
		for (int i = 0; i < 3; i++) begin
			// flags clear and data read, then wake just before stop
			apb(1'b1, CTRL_OFF, 32'h0b);
			apb(1'b1, CTRL_OFF, 32'h1b | 32'(md[i]));
			fork
				remote.send(8'h96 + 8'(i), 1'b0, 1'b0, BITP);
				begin
					repeat (5 * BITP) @(negedge pclk);
					check(snz, 1'b1);
					check(run, 1'b0);
				end
			join
			wake_wait();
			check(n >= wt[i] - BITP && n <= wt[i] + 4, 1'b1);
			check(irq, 1'b1);
			apb(1'b0, STATUS_OFF, 32'h0);
			check(rd & 32'h05, 32'h05);
			@(negedge pclk);
			check(irq, 1'b0);
			apb(1'b0, CTRL_OFF, 32'h0);
			check(rd[4], 1'b0);
			apb(1'b0, DATA_OFF, 32'h0);
			check(rd[7:0], 8'h96 + 8'(i));
		end
		note("snooze");
		apb(1'b1, MASK_OFF, 32'h02);
		apb(1'b1, CTRL_OFF, 32'h0f);
		apb(1'b1, CTRL_OFF, 32'h1f);
		remote.send(8'h5a, 1'b1, 1'b0, BITP);
		wake_wait();
		check(irq, 1'b0);
		apb(1'b0, STATUS_OFF, 32'h0);
		check(rd & 32'h72, 32'h0);
		note("suppress");
		apb(1'b0, 8'h20, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		note("unmapped");
		stop_test();
	end

	// watchdog: the tests need well under half this span
	initial begin
		repeat (80000) @(posedge pclk);
		miscompares++;
		stop_test();
	end
endmodule
`default_nettype wire
